//--- hw/csb_pkg.sv
package csb_pkg;
  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_SKIP_REG_CLR = 3'h1;
  localparam logic [2:0] OP_SKIP_REG_SET = 3'h2;
  localparam logic [2:0] OP_SKIP_IO_CLR = 3'h3;
  localparam logic [2:0] OP_SKIP_IO_SET = 3'h4;
  localparam logic [2:0] OP_BR_FLAG_SET = 3'h5;
  localparam logic [2:0] OP_BR_FLAG_CLR = 3'h6;
  localparam logic [2:0] OP_BR_EQUAL = 3'h7;
  localparam int ZERO_FLAG_BIT = 1;

  // Decoded instruction handed in by the core
  typedef struct packed {
    logic [2:0] op;
    logic [2:0] bit_sel;
    logic [7:0] work_reg;
    logic [7:0] io_reg;
    logic [7:0] status_flags_register;
    logic signed [OFS_W-1:0] offset;
    logic next_is_two_word;
  } csb_instr_t;

  typedef enum logic [1:0] {CSB_IDLE, CSB_WAIT} csb_state_t;
endpackage

//--- hw/csb_unit.sv
`timescale 1ns/1ns
module csb_unit
  import csb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire csb_instr_t INSTR,
  output logic INSTR_READY,
  output logic [PC_W-1:0] PC,
  output logic PC_UPDATE,
  output logic TAKEN
);

  // ----------------------------------------
  // State and address registers
  // ----------------------------------------
  csb_state_t state_reg;
  csb_state_t state_next;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] pend_reg;
  logic [PC_W-1:0] pend_next;
  logic [1:0] wait_reg;
  logic [1:0] wait_next;
  logic upd_reg;
  logic upd_next;
  logic taken_reg;
  logic taken_next;
  logic ready_reg;
  logic ready_next;

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  logic op_skip_reg_clr;
  logic op_skip_reg_set;
  logic op_skip_io_clr;
  logic op_skip_io_set;
  logic op_br_flag_set;
  logic op_br_flag_clr;
  logic op_br_equal;
  logic is_skip;
  logic is_branch;
  logic accept;

  // One strobe per operation code except OP_NONE
  assign op_skip_reg_clr = (INSTR.op == OP_SKIP_REG_CLR);
  assign op_skip_reg_set = (INSTR.op == OP_SKIP_REG_SET);
  assign op_skip_io_clr = (INSTR.op == OP_SKIP_IO_CLR);
  assign op_skip_io_set = (INSTR.op == OP_SKIP_IO_SET);
  assign op_br_flag_set = (INSTR.op == OP_BR_FLAG_SET);
  assign op_br_flag_clr = (INSTR.op == OP_BR_FLAG_CLR);
  assign op_br_equal = (INSTR.op == OP_BR_EQUAL);
  // Groups of operations
  assign is_skip = op_skip_reg_clr || op_skip_reg_set || op_skip_io_clr || op_skip_io_set;
  assign is_branch = op_br_flag_set || op_br_flag_clr || op_br_equal;
  // Code zero and a busy unit both refuse the offer
  assign accept = INSTR_VALID && (state_reg == CSB_IDLE) && (is_skip || is_branch);

  // ----------------------------------------
  // Tested bits
  // ----------------------------------------
  logic reg_bit;
  logic io_bit;
  logic flag_bit;
  logic zero_flag;

  // Bit of the working register under test
  csb_bit_pick csb_bit_pick_reg_i (
    .word(INSTR.work_reg),
    .sel(INSTR.bit_sel),
    .picked(reg_bit)
  );

  // Bit of the I/O byte under test
  csb_bit_pick csb_bit_pick_io_i (
    .word(INSTR.io_reg),
    .sel(INSTR.bit_sel),
    .picked(io_bit)
  );

  // Status flag chosen by the flag index
  csb_bit_pick csb_bit_pick_flag_i (
    .word(INSTR.status_flags_register),
    .sel(INSTR.bit_sel),
    .picked(flag_bit)
  );

  // Zero flag at its fixed position
  csb_bit_pick csb_bit_pick_zero_i (
    .word(INSTR.status_flags_register),
    .sel(3'(ZERO_FLAG_BIT)),
    .picked(zero_flag)
  );

  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  logic cond_skip;
  logic cond_branch;
  logic cond;

  // Skip tests on a register or I/O bit
  assign cond_skip = (op_skip_reg_clr && !reg_bit) ||
                     (op_skip_reg_set && reg_bit) ||
                     (op_skip_io_clr && !io_bit) ||
                     (op_skip_io_set && io_bit);
  // Branch tests on a status flag or the zero flag
  assign cond_branch = (op_br_flag_set && flag_bit) ||
                       (op_br_flag_clr && !flag_bit) ||
                       (op_br_equal && zero_flag);
  // Any condition that moves the PC off its sequence
  assign cond = cond_skip || cond_branch;

  // ----------------------------------------
  // Target address and extra cycles
  // ----------------------------------------
  logic [PC_W-1:0] ofs_ext;
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] pc_branch;
  logic [PC_W-1:0] skip_step;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_target;
  logic [1:0] skip_wait;
  logic [1:0] cycles_needed;

  // Offset sign-extended to the PC width
  assign ofs_ext = {{(PC_W-OFS_W){INSTR.offset[OFS_W-1]}}, INSTR.offset};
  // Candidate addresses; all wrap at the top of the PC range
  assign pc_seq = pc_reg + PC_STEP_ONE;
  assign pc_branch = pc_reg + ofs_ext + PC_STEP_ONE;
  // Skip over one or two words
  assign skip_step = INSTR.next_is_two_word ? PC_STEP_THREE : PC_STEP_TWO;
  assign pc_skip = pc_reg + skip_step;
  // Untaken ops fall through to the next word
  assign pc_target = !cond ? pc_seq : (cond_branch ? pc_branch : pc_skip);
  // One extra cycle per skipped word, one for a taken branch
  assign skip_wait = INSTR.next_is_two_word ? WAIT_TWO : WAIT_ONE;
  assign cycles_needed = !cond ? WAIT_NONE : (cond_branch ? WAIT_ONE : skip_wait);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Next-state selection
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    pend_next = pend_reg;
    wait_next = wait_reg;
    upd_next = 1'h0;
    taken_next = taken_reg;
    case (state_reg)
      CSB_IDLE: begin
        if (accept) begin
          taken_next = cond;
          if (cycles_needed == WAIT_NONE) begin
            pc_next = pc_target;
            upd_next = 1'h1;
          end else begin
            pend_next = pc_target;
            wait_next = cycles_needed;
            state_next = CSB_WAIT;
          end
        end
      end
      CSB_WAIT: begin
        // Last extra cycle loads the pending target
        if (wait_reg <= WAIT_ONE) begin
          pc_next = pend_reg;
          upd_next = 1'h1;
          state_next = CSB_IDLE;
        end
        wait_next = wait_reg - WAIT_ONE;
      end
      default: state_next = CSB_IDLE;
    endcase
  end

  // Ready follows the state the unit moves to
  assign ready_next = (state_next == CSB_IDLE);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Control state; status flags are never written here
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_reg <= CSB_IDLE;
      wait_reg <= WAIT_NONE;
      upd_reg <= 1'h0;
      taken_reg <= 1'h0;
      ready_reg <= 1'h1;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      upd_reg <= upd_next;
      taken_reg <= taken_next;
      ready_reg <= ready_next;
    end
  end

  // Program counter and pending target
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pc_reg <= PC_RESET;
      pend_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
      pend_reg <= pend_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All outputs come straight from registers
  assign INSTR_READY = ready_reg;
  assign PC = pc_reg;
  assign PC_UPDATE = upd_reg;
  assign TAKEN = taken_reg;

endmodule

// ----------------------------------------
// Bit selection
// ----------------------------------------
// One bit of a word, picked by a run-time index
module csb_bit_pick
  import csb_pkg::*;
#(
  parameter int WORD_W = 8,
  parameter int SEL_W = 3
)
(
  input wire logic [WORD_W-1:0] word,
  input wire logic [SEL_W-1:0] sel,
  output logic picked
);

  assign picked = word[sel];

endmodule

//--- testbench/cond_skip_branch_unit_tb_top.sv
`timescale 1ns/1ns
module cond_skip_branch_unit_tb_top
  import csb_pkg::*;
;
  logic CLK = 1'h0, RST_B = 1'h0, INSTR_VALID = 1'h0, INSTR_READY, PC_UPDATE, TAKEN;
  csb_instr_t INSTR = '0;
  logic [PC_W-1:0] PC, pc_m = '0;
  int failures = 0, tests_run = 0;
  always #2 CLK = ~CLK;
  csb_unit csb_unit_i (.CLK(CLK), .RST_B(RST_B), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .INSTR_READY(INSTR_READY), .PC(PC), .PC_UPDATE(PC_UPDATE), .TAKEN(TAKEN));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Offer one op, judge delay, outcome and new PC
  task automatic issue(logic [2:0] op, logic [7:0] v, logic [6:0] k, logic two, logic tk);
    int n;
    logic [15:0] d;
    d = !tk ? 16'h1 : (op > 3'h4 ? 16'h2 : 16'h2 + two);
    @(posedge CLK);
    INSTR_VALID <= 1'h1;
    INSTR <= '{op, 3'h3, v, v, v, k, two};
    @(posedge CLK);
    INSTR_VALID <= 1'h0;
    for (n = 1; n < 6; n++) begin
      #1;
      if (PC_UPDATE === 1'h1) break;
      @(posedge CLK);
    end
    if (n == 6) begin
      failures++;
      stop_test();
    end
    pc_m = op > 3'h4 && tk ? pc_m + {{9{k[6]}}, k} + 16'h1 : pc_m + d;
    chk("delay", d, 16'(n));
    chk("taken", 16'(tk), 16'(TAKEN));
    chk("pc", pc_m, PC);
    chk("ready", 16'h1, 16'(INSTR_READY));
  endtask
  // Code zero, then an offer held while the unit is busy
  task automatic t_refuse();
    @(posedge CLK);
    INSTR_VALID <= 1'h1;
    INSTR <= '{OP_NONE, 3'h3, 8'h08, 8'h08, 8'h08, 7'h0, 1'h1};
    @(posedge CLK);
    INSTR.op <= OP_SKIP_REG_SET;
    repeat (3) @(posedge CLK);
    INSTR_VALID <= 1'h0;
    #1;
    chk("held pc", pc_m + 16'h3, PC);
    chk("held update", 16'h1, 16'(PC_UPDATE));
    pc_m = pc_m + 16'h3;
  endtask
  // Skip ops, both bit values, both follower lengths
  task automatic t_skip();
    for (int c = 4; c < 20; c++) issue(3'(c / 4), c[0] ? 8'h08 : 8'hf7, 7'h0, c[1], c[0] != c[2]);
  endtask
  // Branch ops, true and false; flag branches at both offset ends, equal branch at 7'h40 only
  task automatic t_branch();
    for (int c = 0; c < 4; c++) begin
      issue(OP_BR_FLAG_SET, {4'h0, c[0], 3'h0}, c[1] ? 7'h40 : 7'h3f, 1'h0, c[0]);
      issue(OP_BR_FLAG_CLR, {4'h0, c[0], 3'h0}, c[1] ? 7'h40 : 7'h3f, 1'h1, !c[0]);
      issue(OP_BR_EQUAL, {6'h0, c[0], 1'h0}, 7'h40, 1'h0, c[0]);
    end
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RST_B <= 1'h1;
    t_skip();
    t_branch();
    t_refuse();
    stop_test();
  end
endmodule

//--- testbench/csb_props.sv
`timescale 1ns/1ns
module csb_props
  import csb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire csb_instr_t INSTR,
  input wire logic INSTR_READY,
  input wire logic [PC_W-1:0] PC,
  input wire logic PC_UPDATE,
  input wire logic TAKEN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Accepted op and its condition
  wire acc = INSTR_VALID && INSTR_READY && INSTR.op != OP_NONE;
  wire [7:0] src = INSTR.op < OP_SKIP_IO_CLR ? INSTR.work_reg : INSTR.io_reg;
  wire skip = acc && INSTR.op < OP_BR_FLAG_SET && src[INSTR.bit_sel] != INSTR.op[0];
  wire two = INSTR.next_is_two_word;
  wire flag = INSTR.status_flags_register[INSTR.bit_sel];
  wire bs = acc && INSTR.op == OP_BR_FLAG_SET && flag;
  wire bc = acc && INSTR.op == OP_BR_FLAG_CLR && !flag;
  wire be = acc && INSTR.op == OP_BR_EQUAL && INSTR.status_flags_register[ZERO_FLAG_BIT];
  wire [PC_W-1:0] tgt = PC + {{(PC_W-OFS_W){INSTR.offset[OFS_W-1]}}, INSTR.offset} + PC_STEP_ONE;
  a_br_set: assert property (bs |-> ##2 PC_UPDATE && PC == $past(tgt, 2))
    else $error("br set");
  a_br_clr: assert property (bc |-> ##2 PC_UPDATE && PC == $past(tgt, 2))
    else $error("br clr");
  a_br_equal: assert property (be |-> ##2 PC_UPDATE && PC == $past(tgt, 2))
    else $error("br eq");
  a_br_wait: assert property (bs || bc || be |=> !PC_UPDATE && TAKEN)
    else $error("br wait");
  a_skip_one: assert property (skip && !two |-> ##2 PC_UPDATE && PC == $past(PC, 2) + PC_STEP_TWO)
    else $error("skip one");
  a_skip_two: assert property (skip && two |=> !PC_UPDATE [*2] ##1 PC_UPDATE && PC == $past(PC, 3) + PC_STEP_THREE)
    else $error("skip two");
  a_skip_flag: assert property (skip |=> TAKEN && !INSTR_READY)
    else $error("skip flag");
  a_not_taken: assert property (acc && !skip && !bs && !bc && !be |=> PC_UPDATE && PC == $past(PC) + PC_STEP_ONE)
    else $error("untaken");
endmodule
bind csb_unit csb_props csb_props_i (.CLK(CLK), .RST_B(RST_B), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
  .INSTR_READY(INSTR_READY), .PC(PC), .PC_UPDATE(PC_UPDATE), .TAKEN(TAKEN));
